//--- rtl/fadc_ctrl.v
// Flash converter phase control, conversion pipeline and output port
//
// Behaviour
// - Phase select low: sample during clock low
// - Phase select low: balance during clock high
// - Phase select level picks sample and balance levels
// - Output enable low floats data and flag
// - Both high: float data, drive flag
// - Result appears after next same-polarity edge
`timescale 1ns/1ps
`include "fadc_consts.vh"

module fadc_ctrl #(
  parameter DATA_W = `FADC_DATA_W,
  parameter CODE_W = `FADC_CODE_W,
  parameter COMP_N = `FADC_COMP_N,
  parameter CNT_W = `FADC_CNT_W
) (
  // System
  input wire clock,
  input wire rst_n,
  input wire clock_en,
  // Converter clock and phase select
  input wire conv_clk,
  input wire phase_sel,
  // Comparator array states
  input wire [COMP_N-1:0] comp_therm,
  // Output enables
  input wire low_bits_float_ctrl,
  input wire output_enable_n,
  // Data pins, bit 0 is sample_bit_lsb, top bit sample_bit_msb
  output reg [DATA_W-1:0] sample_bits,
  output wire [DATA_W-1:0] sample_bits_oe,
  // Overflow pin
  output reg range_exceed_flag,
  output wire range_exceed_flag_oe,
  // Status
  output wire sample_phase,
  output wire balance_phase,
  output reg result_strobe,
  output reg result_suspect,
  output reg sample_overtime
);

  // ****************************************
  // Phase selection
  // ****************************************
  // The select complements the clock as it enters; sample level follows it
  wire sample_active;

  assign sample_active = ~(conv_clk ^ phase_sel);
  assign sample_phase = sample_active;
  assign balance_phase = ~sample_active;

  reg prev_sample;
  wire end_sample;
  wire end_balance;

  // Ending a sample latches comparators; ending a balance moves them on
  assign end_sample = prev_sample & ~sample_active;
  assign end_balance = ~prev_sample & sample_active;

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prev_sample <= 1'b0;
    end else if (clock_en) begin
      prev_sample <= sample_active;
    end
  end

  // ****************************************
  // Sample length watch
  // ****************************************
  // Capacitors droop in a long sample; results from one are marked
  // Limit taken as an integer, then cut to the counter width on purpose
  localparam integer SAMPLE_MAX_I = `FADC_SAMPLE_MAX_CYC;
  localparam [CNT_W-1:0] SAMPLE_MAX = SAMPLE_MAX_I[CNT_W-1:0];

  reg [CNT_W-1:0] sample_cnt;
  reg sample_long;
  wire [CNT_W-1:0] next_sample_cnt;

  // Saturate so an endless sample cannot wrap back under the limit
  function [CNT_W-1:0] sat_inc;
    input [CNT_W-1:0] val;
    begin
      if (val == {CNT_W{1'b1}}) begin
        sat_inc = val;
      end else begin
        sat_inc = val + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  endfunction

  assign next_sample_cnt = sat_inc(sample_cnt);

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sample_cnt <= {CNT_W{1'b0}};
      sample_long <= 1'b0;
      sample_overtime <= 1'b0;
    end else if (clock_en) begin
      sample_overtime <= 1'b0;
      if (sample_active) begin
        sample_cnt <= next_sample_cnt;
        if (next_sample_cnt > SAMPLE_MAX) begin
          if (!sample_long) begin
            sample_overtime <= 1'b1;
          end
          sample_long <= 1'b1;
        end
      end else begin
        sample_cnt <= {CNT_W{1'b0}};
        if (end_sample) begin
          sample_long <= 1'b0;
        end
      end
    end
  end

  // ****************************************
  // First latch row
  // ****************************************
  reg [COMP_N-1:0] stage1;
  reg stage1_valid;
  reg stage1_suspect;

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      stage1 <= {COMP_N{1'b0}};
      stage1_valid <= 1'b0;
      stage1_suspect <= 1'b0;
    end else if (clock_en && end_sample) begin
      stage1 <= comp_therm;
      stage1_valid <= 1'b1;
      stage1_suspect <= sample_long;
    end
  end

  // ****************************************
  // Second latch row
  // ****************************************
  // Held over the balance phase to give the comparators settling time
  reg [COMP_N-1:0] stage2;
  reg stage2_valid;
  reg stage2_suspect;

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      stage2 <= {COMP_N{1'b0}};
      stage2_valid <= 1'b0;
      stage2_suspect <= 1'b0;
    end else if (clock_en && end_balance) begin
      stage2 <= stage1;
      stage2_valid <= stage1_valid;
      stage2_suspect <= stage1_suspect;
    end
  end

  // ****************************************
  // Decoder
  // ****************************************
  wire [CODE_W-1:0] dec_code;

  fadc_therm_decode #(
    .COMP_N(COMP_N),
    .CODE_W(CODE_W)
  ) u_decode (
    .therm(stage2),
    .code(dec_code)
  );

  // ****************************************
  // Output register
  // ****************************************
  // Loaded on the next sample end, one same-polarity edge after capture
  wire load_result;

  assign load_result = end_sample & stage2_valid;

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sample_bits <= `FADC_DATA_RST;
      range_exceed_flag <= `FADC_OVF_RST;
      result_strobe <= 1'b0;
      result_suspect <= 1'b0;
    end else if (clock_en) begin
      result_strobe <= 1'b0;
      if (load_result) begin
        sample_bits <= dec_code[DATA_W-1:0];
        range_exceed_flag <= dec_code[`FADC_OVF_BIT];
        result_strobe <= 1'b1;
        result_suspect <= stage2_suspect;
      end
    end
  end

  // ****************************************
  // Three-state enables
  // ****************************************
  // Enables act at once, independent of the conversion clock
  // Returns data drive then flag drive; the active-low enable wins over all
  function [1:0] pin_drive;
    input float_ctrl;
    input enable_n;
    begin
      case ({float_ctrl, enable_n})
        2'b01: begin
          pin_drive = 2'b11;
        end
        2'b11: begin
          pin_drive = 2'b01;
        end
        default: begin
          pin_drive = 2'b00;
        end
      endcase
    end
  endfunction

  wire [1:0] drive;

  assign drive = pin_drive(low_bits_float_ctrl, output_enable_n);
  assign sample_bits_oe = {DATA_W{drive[1]}};
  assign range_exceed_flag_oe = drive[0];

endmodule

//--- rtl/fadc_consts.vh
// Constants for the flash converter control block
`ifndef FADC_CONSTS_VH
`define FADC_CONSTS_VH

// ****************************************
// Widths and field positions
// ****************************************
`define FADC_DATA_W 8
`define FADC_CODE_W 9
`define FADC_COMP_N 256
`define FADC_OVF_BIT 8

// ****************************************
// Reset values
// ****************************************
`define FADC_DATA_RST 8'h00
`define FADC_OVF_RST 1'b0
`define FADC_CODE_RST 9'h000

// ****************************************
// Timing
// ****************************************
`define FADC_CLK_PERIOD_NS 100
`define FADC_SAMPLE_MAX_NS 500
// Longest time: round down, never below one cycle
`define FADC_SAMPLE_MAX_CYC \
  (((`FADC_SAMPLE_MAX_NS / `FADC_CLK_PERIOD_NS) < 1) ? 1 : \
  (`FADC_SAMPLE_MAX_NS / `FADC_CLK_PERIOD_NS))
`define FADC_CNT_W 8

`endif

//--- rtl/fadc_therm_decode.v
// Comparator thermometer to binary code plus overflow decoder
`timescale 1ns/1ps

module fadc_therm_decode #(
  parameter COMP_N = 256,
  parameter CODE_W = 9
) (
  // Comparator states, bit i high when input exceeds tap i
  input wire [COMP_N-1:0] therm,
  // Binary count of tripped comparators
  output wire [CODE_W-1:0] code
);

  // ****************************************
  // Ones count
  // ****************************************
  // A count tolerates thermometer bubbles better than a priority search
  function [CODE_W-1:0] count_ones;
    input [COMP_N-1:0] vec;
    integer i;
    begin
      count_ones = {CODE_W{1'b0}};
      for (i = 0; i < COMP_N; i = i + 1) begin
        count_ones = count_ones + {{(CODE_W-1){1'b0}}, vec[i]};
      end
    end
  endfunction

  assign code = count_ones(therm);

endmodule

//--- tb/fadc_chk_assertions.sv
// Port checker for the converter control block
`timescale 1ns/1ps
module fadc_chk #(parameter DATA_W = 8, parameter COMP_N = 256) (
  input wire clock, input wire rst_n, input wire conv_clk, input wire phase_sel,
  input wire [COMP_N-1:0] comp_therm, input wire low_bits_float_ctrl,
  input wire output_enable_n, input wire [DATA_W-1:0] sample_bits,
  input wire [DATA_W-1:0] sample_bits_oe, input wire range_exceed_flag,
  input wire range_exceed_flag_oe, input wire sample_phase, input wire balance_phase,
  input wire result_strobe, input wire clock_en, input wire sample_overtime
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Sample length limit in clock cycles: 500 ns at a 100 ns clock
  localparam int SAMPLE_CYC = 5;
  // Comparator image piped as the rules say: captured at a sample end,
  // moved on at the following balance end
  reg prev_sp;
  reg [3:0] sp_cnt;
  reg [COMP_N-1:0] row1, row2;
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prev_sp <= 1'b0;
      sp_cnt <= 4'h0;
      row1 <= '0;
      row2 <= '0;
    end else if (clock_en) begin
      prev_sp <= sample_phase;
      sp_cnt <= !sample_phase ? 4'h0 : (sp_cnt == 4'hF) ? sp_cnt : sp_cnt + 4'h1;
      if (prev_sp && !sample_phase) row1 <= comp_therm;
      if (!prev_sp && sample_phase) row2 <= row1;
    end
  end
  // ****************************************
  // Sample end two edges back
  // ****************************************
  sequence s_done;
    $past(sample_phase, 2) && !$past(sample_phase);
  endsequence
  chk_phase_low: assert property (!phase_sel |-> sample_phase == !conv_clk)
    else $error("sample level wrong");
  chk_bal_high: assert property (!phase_sel && conv_clk |-> balance_phase)
    else $error("balance level wrong");
  chk_phase_sel: assert property (phase_sel |-> sample_phase == conv_clk)
    else $error("phase select ignored");
  chk_float_all: assert property (!output_enable_n |-> !range_exceed_flag_oe
    && sample_bits_oe == 0) else $error("pins not floated");
  chk_drive_all: assert property (output_enable_n && !low_bits_float_ctrl |->
    &sample_bits_oe && range_exceed_flag_oe) else $error("pins not driven");
  chk_data_float: assert property (output_enable_n && low_bits_float_ctrl |->
    sample_bits_oe == 0 && range_exceed_flag_oe) else $error("data float wrong");
  chk_result_late: assert property (result_strobe |-> s_done)
    else $error("result at wrong edge");
  chk_code_value: assert property (result_strobe |->
    {range_exceed_flag, sample_bits} == $countones(row2))
    else $error("result code wrong");
  chk_overtime_at: assert property (sample_overtime |-> sp_cnt == SAMPLE_CYC + 1)
    else $error("overtime at wrong cycle");
  chk_overtime_due: assert property (clock_en && sample_phase && sp_cnt == SAMPLE_CYC
    |=> sample_overtime) else $error("overtime missed");
endmodule
bind fadc_ctrl fadc_chk #(.DATA_W(DATA_W), .COMP_N(COMP_N)) u_chk (.clock(clock),
  .rst_n(rst_n), .conv_clk(conv_clk), .phase_sel(phase_sel), .comp_therm(comp_therm),
  .low_bits_float_ctrl(low_bits_float_ctrl), .output_enable_n(output_enable_n),
  .sample_bits(sample_bits), .sample_bits_oe(sample_bits_oe),
  .range_exceed_flag(range_exceed_flag), .range_exceed_flag_oe(range_exceed_flag_oe),
  .sample_phase(sample_phase), .balance_phase(balance_phase),
  .result_strobe(result_strobe), .clock_en(clock_en), .sample_overtime(sample_overtime));

//--- tb/fadc_cap.sv
// Capture logic model: makes the converter clock, latches results
`timescale 1ns/1ps
module fadc_cap (
  input wire clock, input wire run, input wire slow, input wire phase_sel,
  input wire [7:0] sample_bits, input wire range_exceed_flag, input wire result_strobe,
  output reg conv_clk, output reg [8:0] cap
);
  reg [2:0] cnt;
  initial begin
    conv_clk = 1'b1;
    cnt = 3'h0;
    cap = 9'h000;
  end
  // Idle parks in balance; slow mode overstays the sample on purpose
  always @(negedge clock) begin
    cnt <= cnt + 3'h1;
    if (!run) conv_clk <= ~phase_sel;
    else if (cnt >= (slow ? 3'h6 : 3'h1)) begin
      conv_clk <= ~conv_clk;
      cnt <= 3'h0;
    end
  end
  always @(posedge clock) if (result_strobe) cap <= {range_exceed_flag, sample_bits};
endmodule

//--- tb/tb.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin num_errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module tb;
  reg clock = 1'b0, rst_n = 1'b0, clock_en = 1'b1, phase_sel = 1'b0;
  reg float_ctrl = 1'b0, oe_n = 1'b1, run = 1'b0, slow = 1'b0;
  reg [255:0] therm = 256'h0;
  wire [7:0] bits, bits_oe;
  wire flag, flag_oe, sph, bph, strobe, suspect, overtime, conv_clk;
  wire [8:0] cap;
  integer num_errors = 0, tests_run = 0, i;
  integer vals [0:4] = '{0, 1, 127, 255, 256};
  always #50 clock = ~clock;
  fadc_ctrl uut (.clock(clock), .rst_n(rst_n), .clock_en(clock_en), .conv_clk(conv_clk),
    .phase_sel(phase_sel), .comp_therm(therm), .low_bits_float_ctrl(float_ctrl),
    .output_enable_n(oe_n), .sample_bits(bits), .sample_bits_oe(bits_oe),
    .range_exceed_flag(flag), .range_exceed_flag_oe(flag_oe), .sample_phase(sph),
    .balance_phase(bph), .result_strobe(strobe), .result_suspect(suspect),
    .sample_overtime(overtime));
  fadc_cap cap_model (.clock(clock), .run(run), .slow(slow), .phase_sel(phase_sel),
    .sample_bits(bits), .range_exceed_flag(flag), .result_strobe(strobe),
    .conv_clk(conv_clk), .cap(cap));
  task stop_test;
    begin
      $display("checks %0d errors %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  // Bounded wait for a strobe (sel 0) or an overtime pulse (sel 1)
  task wait_on(input integer sel);
    integer k;
    begin
      k = 0;
      @(posedge clock) #1;
      while ((sel ? overtime : strobe) !== 1'b1 && k < 60) begin
        @(posedge clock) #1;
        k++;
      end
      if ((sel ? overtime : strobe) !== 1'b1) begin
        num_errors++;
        stop_test;
      end
    end
  endtask
  // Pipeline needs several results before the new level shows
  task conv(input integer n);
    begin
      @(negedge clock) therm = {256{1'b1}} >> (256 - n);
      repeat (3) wait_on(0);
      @(posedge clock) #1 `CHK(cap, n[8:0])
    end
  endtask
  initial begin
    repeat (6) @(posedge clock);
    @(negedge clock) rst_n = 1'b1;
    for (i = 0; i < 4; i++) begin
      @(negedge clock) {float_ctrl, oe_n} = i[1:0];
      #1 `CHK({flag_oe, bits_oe}, (i == 1) ? 9'h1FF : (i == 3) ? 9'h100 : 9'h000)
    end
    for (i = 0; i < 2; i++) begin
      @(negedge clock) phase_sel = i[0];
      @(negedge clock) #1 `CHK({sph, bph}, 2'b01)
    end
    @(negedge clock) {phase_sel, float_ctrl, oe_n, run} = 4'h3;
    for (i = 0; i < 5; i++) conv(vals[i]);
    @(negedge clock) phase_sel = 1'b1;
    conv(170);
    // Frozen: a running converter clock must move nothing
    @(negedge clock) run = 1'b0;
    repeat (4) @(negedge clock);
    {clock_en, run} = 2'b01;
    i = 0;
    repeat (12) @(negedge clock) i = i + (strobe | overtime);
    `CHK(i, 0)
    `CHK({flag, bits}, 9'h0AA)
    run = 1'b0;
    repeat (3) @(negedge clock);
    {clock_en, run} = 2'b11;
    @(negedge clock) slow = 1'b1;
    wait_on(1);
    repeat (2) wait_on(0);
    `CHK(suspect, 1'b1)
    @(negedge clock) slow = 1'b0;
    repeat (3) wait_on(0);
    `CHK(suspect, 1'b0)
    @(negedge clock) rst_n = 1'b0;
    #1 `CHK({flag, bits}, 9'h000)
    @(negedge clock) rst_n = 1'b1;
    conv(200);
    stop_test;
  end
endmodule
